// ### logic/hyp_env_pkg.sv
// constants for the guest environment register bank
package hyp_env_pkg;
  // =========================================================
  // bus register map (byte offsets, one 32-bit word each)
  localparam logic [7:0] OFS_ENV_CFG_LO = 8'h00;
  localparam logic [7:0] OFS_ENV_CFG_HI = 8'h04;
  localparam logic [7:0] OFS_CNT_GATE = 8'h08;
  localparam logic [7:0] OFS_TOFS_LO = 8'h0c;
  localparam logic [7:0] OFS_TOFS_HI = 8'h10;
  localparam logic [7:0] OFS_FADDR_LO = 8'h14;
  localparam logic [7:0] OFS_FADDR_HI = 8'h18;
  localparam logic [7:0] OFS_TINFO_LO = 8'h1c;
  localparam logic [7:0] OFS_TINFO_HI = 8'h20;
  localparam logic [7:0] OFS_GTIME_LO = 8'h24;
  localparam logic [7:0] OFS_GTIME_HI = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;
  // =========================================================
  // environment configuration field positions
  localparam int ENV_IO_FENCE_COVERS_MEMORY = 0;
  localparam int ENV_LPE = 2;
  localparam int ENV_SSE = 3;
  localparam int ENV_DTE = 59;
  localparam int ENV_HW_ACCESS_DIRTY_UPDATE_ENABLE = 61;
  localparam int ENV_PAGE_MEMTYPE_ENABLE = 62;
  // optional translation features present in this hart
  localparam logic HAS_PAGE_MEMTYPE = 1'b1;
  localparam logic HAS_HW_AD_UPDATE = 1'b1;
  localparam logic [63:0] ENV_IMPL_MASK =
    (64'h1 << ENV_IO_FENCE_COVERS_MEMORY) | (64'h1 << ENV_LPE) | (64'h1 << ENV_SSE) |
    (64'h1 << ENV_DTE) | ({63'h0, HAS_HW_AD_UPDATE} << ENV_HW_ACCESS_DIRTY_UPDATE_ENABLE) |
    ({63'h0, HAS_PAGE_MEMTYPE} << ENV_PAGE_MEMTYPE_ENABLE);
  // =========================================================
  // counter gate: cycle, time, retired and counters 3..7 exist
  localparam int CNT_NUM = 32;
  localparam int CNT_CY = 0;
  localparam int CNT_TM = 1;
  localparam int CNT_IR = 2;
  localparam logic [31:0] CNT_IMPL_MASK = 32'h0000_00ff;
  // =========================================================
  // trap capture
  localparam int GPA_SHIFT = 2;
  localparam logic [63:0] FADDR_IMPL_MASK = 64'h003f_ffff_ffff_ffff;
  localparam logic [63:0] TINFO_IMPL_MASK = 64'h0000_0000_ffff_ffff;
  localparam logic [63:0] RST_64 = 64'h0;
  localparam logic [31:0] RST_32 = 32'h0;
  // status word bit positions
  localparam int ST_VIRT = 0;
  localparam int ST_LAST_GPF = 1;
  localparam int ST_CNT_FAULT = 2;
endpackage

// ### logic/counter_gate_check.sv
// guest counter read permission check
`timescale 1ns/1ps
module counter_gate_check (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic req,
  input wire logic [4:0] idx,
  input wire logic virt,
  input wire logic guest_user,
  input wire logic [31:0] guest_gate,
  input wire logic [31:0] machine_gate,
  input wire logic [31:0] super_gate,
  output logic done_r,
  output logic grant_r,
  output logic virt_fault_r
);
  import hyp_env_pkg::*;

  logic [CNT_NUM-1:0] deny_v;

  // =========================================================
  // per counter: guest gate must be set, and in guest user both gates
  genvar g;
  generate
    for (g = 0; g < CNT_NUM; g = g + 1) begin : gen_cnt
      assign deny_v[g] = virt & machine_gate[g] &
        (~guest_gate[g] | (guest_user & ~super_gate[g]));
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      done_r <= 1'b0;
      grant_r <= 1'b0;
      virt_fault_r <= 1'b0;
    end else begin
      done_r <= req;
      grant_r <= req & ~deny_v[idx];
      virt_fault_r <= req & deny_v[idx];
    end
  end
endmodule

// ### logic/hypervisor_guest_env_csr_bank.sv
// guest environment control and status register bank
// Functional notes
// - io_fence_covers_memory while virtualized: io fence bits order memory
// - io_fence_covers_memory: acquire/release io atomics also order memory
// - page memtype enable gates guest first-stage types
// - ad update enable: hardware update, else fault
// - landing pad off: no tracking, marker is no-op
// - shadow stack off: fallbacks, reserved pte, swap traps
// - double trap guard off: guest flag reads zero
// - upper config word aliases bits 63:32
// - clear guest gate traps virtual instruction read
// - guest user needs guest and supervisor gate
// - counter gate exists, some bits hardwired zero
// - guest time is real time plus offset
// - upper offset word aliases bits 63:32
// - trap writes gpa>>2 on guest fault, else zero
// - implicit walk fault records walk address
// - recorded address matches faulting portion
// - fault address holds gpa bits 33:2 upward
// - fault address keeps zero and a subset
// - every trap writes trap instruction info
// - trap info keeps only hardware-writable values
`timescale 1ns/1ps
module hypervisor_guest_env_csr_bank (
  input wire logic clk_sys,
  input wire logic nrst,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // hart state
  input wire logic virt_mode,
  input wire logic guest_user,
  input wire logic [63:0] real_time,
  // ordering requests: {pi, po, si, so}
  input wire logic [3:0] fence_io_bits,
  input wire logic amo_io_acqrel,
  // translation and control-flow requests
  input wire logic ad_update_need,
  input wire logic machine_ss_enable,
  input wire logic ss_swap_op,
  // counter read check
  input wire logic cnt_read_req,
  input wire logic [4:0] cnt_read_idx,
  input wire logic [31:0] machine_counter_gate,
  input wire logic [31:0] supervisor_counter_gate,
  // trap into hypervisor level
  input wire logic trap_take,
  input wire logic trap_guest_page_fault,
  input wire logic trap_implicit_walk,
  input wire logic [63:0] trap_gpa,
  input wire logic [63:0] trap_instr_value,
  // effects on the hart
  output logic [3:0] fence_mem_bits_r,
  output logic amo_order_both_r,
  output logic page_memtype_avail_r,
  output logic hw_ad_update_r,
  output logic ad_fault_r,
  output logic landing_pad_track_r,
  output logic landing_pad_nop_r,
  output logic shadow_stack_fallback_r,
  output logic shadow_pte_010_reserved_r,
  output logic super_sse_read_zero_r,
  output logic shadow_swap_virt_instr_r,
  output logic guest_double_trap_off_r,
  output logic [63:0] guest_time_r,
  output logic cnt_done_r,
  output logic cnt_grant_r,
  output logic cnt_virt_fault_r
);
  import hyp_env_pkg::*;

  logic [63:0] env_cfg_r;
  logic [31:0] cnt_gate_r;
  logic [63:0] time_ofs_r;
  logic [63:0] fault_addr_r;
  logic [63:0] trap_info_r;
  logic last_gpf_r;
  logic cnt_fault_seen_r;
  logic [31:0] rd_nxt;
  logic bus_req;
  logic wr_en;
  logic [63:0] fault_addr_nxt;

  // =========================================================
  // bus access decode
  // one wait state: ack follows the cycle after the request is seen
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = bus_req & wb_we_i;

  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic wr_at(input logic [7:0] ofs);
    return wr_en && (wb_adr_i == ofs);
  endfunction

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // =========================================================
  // environment configuration, both words
  // only implemented fields hold state, the rest stays zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      env_cfg_r <= RST_64;
    end else begin
      if (wr_at(OFS_ENV_CFG_LO)) begin
        env_cfg_r[31:0] <= lane_merge(env_cfg_r[31:0], wb_dat_i, wb_sel_i) &
          ENV_IMPL_MASK[31:0];
      end
      if (wr_at(OFS_ENV_CFG_HI)) begin
        env_cfg_r[63:32] <= lane_merge(env_cfg_r[63:32], wb_dat_i, wb_sel_i) &
          ENV_IMPL_MASK[63:32];
      end
    end
  end

  // =========================================================
  // counter gate
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_gate_r <= RST_32;
    end else if (wr_at(OFS_CNT_GATE)) begin
      cnt_gate_r <= lane_merge(cnt_gate_r, wb_dat_i, wb_sel_i) & CNT_IMPL_MASK;
    end
  end

  // =========================================================
  // guest clock offset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      time_ofs_r <= RST_64;
    end else begin
      if (wr_at(OFS_TOFS_LO)) begin
        time_ofs_r[31:0] <= lane_merge(time_ofs_r[31:0], wb_dat_i, wb_sel_i);
      end
      if (wr_at(OFS_TOFS_HI)) begin
        time_ofs_r[63:32] <= lane_merge(time_ofs_r[63:32], wb_dat_i, wb_sel_i);
      end
    end
  end

  // sum wraps on purpose: large offsets act as negative shifts
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      guest_time_r <= RST_64;
    end else begin
      guest_time_r <= real_time + time_ofs_r;
    end
  end

  // =========================================================
  // trap capture
  // hart reports the walk address for implicit faults and the
  // faulting portion for split accesses; low two bits drop out
  always_comb begin
    fault_addr_nxt = RST_64;
    if (trap_guest_page_fault) begin
      fault_addr_nxt = (trap_gpa >> GPA_SHIFT) & FADDR_IMPL_MASK;
    end
  end

  // a trap in the same cycle as a software write wins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fault_addr_r <= RST_64;
    end else if (trap_take) begin
      fault_addr_r <= fault_addr_nxt;
    end else begin
      if (wr_at(OFS_FADDR_LO)) begin
        fault_addr_r[31:0] <= lane_merge(fault_addr_r[31:0], wb_dat_i, wb_sel_i) &
          FADDR_IMPL_MASK[31:0];
      end
      if (wr_at(OFS_FADDR_HI)) begin
        fault_addr_r[63:32] <= lane_merge(fault_addr_r[63:32], wb_dat_i, wb_sel_i) &
          FADDR_IMPL_MASK[63:32];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      trap_info_r <= RST_64;
    end else if (trap_take) begin
      trap_info_r <= trap_instr_value & TINFO_IMPL_MASK;
    end else begin
      if (wr_at(OFS_TINFO_LO)) begin
        trap_info_r[31:0] <= lane_merge(trap_info_r[31:0], wb_dat_i, wb_sel_i) &
          TINFO_IMPL_MASK[31:0];
      end
      if (wr_at(OFS_TINFO_HI)) begin
        trap_info_r[63:32] <= lane_merge(trap_info_r[63:32], wb_dat_i, wb_sel_i) &
          TINFO_IMPL_MASK[63:32];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      last_gpf_r <= 1'b0;
    end else if (trap_take) begin
      last_gpf_r <= trap_guest_page_fault;
    end
  end

  // sticky; a new fault beats a clearing write in the same cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_fault_seen_r <= 1'b0;
    end else if (cnt_virt_fault_r) begin
      cnt_fault_seen_r <= 1'b1;
    end else if (wr_at(OFS_STATUS) && wb_sel_i[0] && wb_dat_i[ST_CNT_FAULT]) begin
      cnt_fault_seen_r <= 1'b0;
    end
  end

  // =========================================================
  // counter permission check
  counter_gate_check u_cnt_check (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .req(cnt_read_req),
    .idx(cnt_read_idx),
    .virt(virt_mode),
    .guest_user(guest_user),
    .guest_gate(cnt_gate_r),
    .machine_gate(machine_counter_gate),
    .super_gate(supervisor_counter_gate),
    .done_r(cnt_done_r),
    .grant_r(cnt_grant_r),
    .virt_fault_r(cnt_virt_fault_r)
  );

  // =========================================================
  // effects on guest execution
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fence_mem_bits_r <= 4'h0;
      amo_order_both_r <= 1'b0;
    end else begin
      fence_mem_bits_r <= (env_cfg_r[ENV_IO_FENCE_COVERS_MEMORY] & virt_mode) ? fence_io_bits : 4'h0;
      amo_order_both_r <= env_cfg_r[ENV_IO_FENCE_COVERS_MEMORY] & virt_mode & amo_io_acqrel;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      page_memtype_avail_r <= 1'b0;
      hw_ad_update_r <= 1'b0;
      ad_fault_r <= 1'b0;
    end else begin
      page_memtype_avail_r <= virt_mode & env_cfg_r[ENV_PAGE_MEMTYPE_ENABLE];
      hw_ad_update_r <= virt_mode & ad_update_need & env_cfg_r[ENV_HW_ACCESS_DIRTY_UPDATE_ENABLE];
      ad_fault_r <= virt_mode & ad_update_need & ~env_cfg_r[ENV_HW_ACCESS_DIRTY_UPDATE_ENABLE];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      landing_pad_track_r <= 1'b0;
      landing_pad_nop_r <= 1'b0;
    end else begin
      landing_pad_track_r <= virt_mode & env_cfg_r[ENV_LPE];
      landing_pad_nop_r <= virt_mode & ~env_cfg_r[ENV_LPE];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shadow_stack_fallback_r <= 1'b0;
      shadow_pte_010_reserved_r <= 1'b0;
      super_sse_read_zero_r <= 1'b1;
      shadow_swap_virt_instr_r <= 1'b0;
    end else begin
      shadow_stack_fallback_r <= virt_mode & ~env_cfg_r[ENV_SSE];
      shadow_pte_010_reserved_r <= virt_mode & ~env_cfg_r[ENV_SSE];
      super_sse_read_zero_r <= ~env_cfg_r[ENV_SSE];
      shadow_swap_virt_instr_r <= virt_mode & ~env_cfg_r[ENV_SSE] &
        machine_ss_enable & ss_swap_op;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      guest_double_trap_off_r <= 1'b1;
    end else begin
      guest_double_trap_off_r <= ~env_cfg_r[ENV_DTE];
    end
  end

  // =========================================================
  // read data
  // unmapped offsets answer with zero so software never hangs
  always_comb begin
    rd_nxt = RST_32;
    case (wb_adr_i)
      OFS_ENV_CFG_LO: rd_nxt = env_cfg_r[31:0];
      OFS_ENV_CFG_HI: rd_nxt = env_cfg_r[63:32];
      OFS_CNT_GATE: rd_nxt = cnt_gate_r;
      OFS_TOFS_LO: rd_nxt = time_ofs_r[31:0];
      OFS_TOFS_HI: rd_nxt = time_ofs_r[63:32];
      OFS_FADDR_LO: rd_nxt = fault_addr_r[31:0];
      OFS_FADDR_HI: rd_nxt = fault_addr_r[63:32];
      OFS_TINFO_LO: rd_nxt = trap_info_r[31:0];
      OFS_TINFO_HI: rd_nxt = trap_info_r[63:32];
      OFS_GTIME_LO: rd_nxt = guest_time_r[31:0];
      OFS_GTIME_HI: rd_nxt = guest_time_r[63:32];
      OFS_STATUS: begin
        rd_nxt[ST_VIRT] = virt_mode;
        rd_nxt[ST_LAST_GPF] = last_gpf_r;
        rd_nxt[ST_CNT_FAULT] = cnt_fault_seen_r;
      end
      default: rd_nxt = RST_32;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= RST_32;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= rd_nxt;
    end else begin
      wb_dat_o <= RST_32;
    end
  end
endmodule

// ### test/hyp_env_checker.sv
// concurrent checks on the guest environment register bank ports
`timescale 1ns/1ps
module hyp_env_checker (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic virt_mode,
  input wire logic guest_user,
  input wire logic [63:0] real_time,
  input wire logic [3:0] fence_mem_bits_r,
  input wire logic amo_io_acqrel,
  input wire logic amo_order_both_r,
  input wire logic ad_update_need,
  input wire logic hw_ad_update_r,
  input wire logic ad_fault_r,
  input wire logic landing_pad_track_r,
  input wire logic landing_pad_nop_r,
  input wire logic machine_ss_enable,
  input wire logic ss_swap_op,
  input wire logic shadow_stack_fallback_r,
  input wire logic shadow_swap_virt_instr_r,
  input wire logic [63:0] guest_time_r,
  input wire logic cnt_read_req,
  input wire logic [4:0] cnt_read_idx,
  input wire logic [31:0] machine_counter_gate,
  input wire logic [31:0] supervisor_counter_gate,
  input wire logic cnt_done_r,
  input wire logic cnt_grant_r,
  input wire logic cnt_virt_fault_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // bus and counter handshakes
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack;
    s_taken |=> s_ack_pulse;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_cnt_answer;
    cnt_read_req |=> cnt_done_r && (cnt_grant_r ^ cnt_virt_fault_r);
  endproperty
  a_cnt_answer: assert property (p_cnt_answer) else $error("counter answer wrong");
  property p_cnt_fault_cause;
    cnt_virt_fault_r |-> $past(virt_mode) && $past(machine_counter_gate[cnt_read_idx]);
  endproperty
  a_cnt_fault_cause: assert property (p_cnt_fault_cause) else $error("fault without cause");
  property p_user_gate;
    cnt_read_req && virt_mode && guest_user && machine_counter_gate[cnt_read_idx] &&
      !supervisor_counter_gate[cnt_read_idx] |=> cnt_virt_fault_r;
  endproperty
  a_user_gate: assert property (p_user_gate) else $error("user read not refused");
  // ==========================================================
  // effects on the hart
  property p_fence_off;
    !virt_mode |=> fence_mem_bits_r == 4'h0;
  endproperty
  a_fence_off: assert property (p_fence_off) else $error("fence widened outside guest");
  property p_amo;
    amo_order_both_r |-> $past(amo_io_acqrel) && $past(virt_mode);
  endproperty
  a_amo: assert property (p_amo) else $error("atomic ordering without cause");
  property p_ad;
    virt_mode && ad_update_need |=> hw_ad_update_r ^ ad_fault_r;
  endproperty
  a_ad: assert property (p_ad) else $error("dirty update neither or both");
  property p_landing_pad_marker_op;
    virt_mode |=> landing_pad_track_r ^ landing_pad_nop_r;
  endproperty
  a_landing_pad_marker_op: assert property (p_landing_pad_marker_op) else $error("landing pad state wrong");
  property p_swap;
    shadow_swap_virt_instr_r |-> shadow_stack_fallback_r && $past(machine_ss_enable && ss_swap_op);
  endproperty
  a_swap: assert property (p_swap) else $error("swap trap without cause");
  // offset unchanged when no bus access was taken two edges back
  property p_time_offset;
    !wb_cyc_i ##2 1'b1 |-> guest_time_r - $past(real_time) ==
      $past(guest_time_r) - $past(real_time, 2);
  endproperty
  a_time_offset: assert property (p_time_offset) else $error("guest time offset drift");
endmodule
bind hypervisor_guest_env_csr_bank hyp_env_checker chk_i (
  .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .virt_mode(virt_mode), .guest_user(guest_user),
  .real_time(real_time), .fence_mem_bits_r(fence_mem_bits_r),
  .amo_io_acqrel(amo_io_acqrel), .amo_order_both_r(amo_order_both_r),
  .ad_update_need(ad_update_need), .hw_ad_update_r(hw_ad_update_r),
  .ad_fault_r(ad_fault_r), .landing_pad_track_r(landing_pad_track_r),
  .landing_pad_nop_r(landing_pad_nop_r), .machine_ss_enable(machine_ss_enable),
  .ss_swap_op(ss_swap_op), .shadow_stack_fallback_r(shadow_stack_fallback_r),
  .shadow_swap_virt_instr_r(shadow_swap_virt_instr_r), .guest_time_r(guest_time_r),
  .cnt_read_req(cnt_read_req), .cnt_read_idx(cnt_read_idx),
  .machine_counter_gate(machine_counter_gate),
  .supervisor_counter_gate(supervisor_counter_gate), .cnt_done_r(cnt_done_r),
  .cnt_grant_r(cnt_grant_r), .cnt_virt_fault_r(cnt_virt_fault_r)
);

// ### test/hypervisor_guest_env_csr_bank_tb.sv
// self-checking bench for the guest environment register bank
`timescale 1ns/1ps
module hypervisor_guest_env_csr_bank_tb;
  import hyp_env_pkg::*;
  logic clk_sys, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, fence_io_bits, fence_mem_bits_r;
  logic [31:0] wb_dat_i, wb_dat_o, machine_counter_gate, supervisor_counter_gate, rd;
  logic virt_mode, guest_user, amo_io_acqrel, ad_update_need, machine_ss_enable, ss_swap_op;
  logic [63:0] real_time, trap_gpa, trap_instr_value, guest_time_r;
  logic cnt_read_req, trap_take, trap_guest_page_fault, trap_implicit_walk;
  logic [4:0] cnt_read_idx;
  logic amo_order_both_r, page_memtype_avail_r, hw_ad_update_r, ad_fault_r;
  logic landing_pad_track_r, landing_pad_nop_r, shadow_stack_fallback_r;
  logic shadow_pte_010_reserved_r, super_sse_read_zero_r, shadow_swap_virt_instr_r;
  logic guest_double_trap_off_r, cnt_done_r, cnt_grant_r, cnt_virt_fault_r;
  int n_mismatch, tests_run;
  hypervisor_guest_env_csr_bank uut (
    .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .virt_mode(virt_mode), .guest_user(guest_user),
    .real_time(real_time), .fence_io_bits(fence_io_bits), .amo_io_acqrel(amo_io_acqrel),
    .ad_update_need(ad_update_need), .machine_ss_enable(machine_ss_enable),
    .ss_swap_op(ss_swap_op), .cnt_read_req(cnt_read_req), .cnt_read_idx(cnt_read_idx),
    .machine_counter_gate(machine_counter_gate),
    .supervisor_counter_gate(supervisor_counter_gate), .trap_take(trap_take),
    .trap_guest_page_fault(trap_guest_page_fault), .trap_implicit_walk(trap_implicit_walk),
    .trap_gpa(trap_gpa), .trap_instr_value(trap_instr_value),
    .fence_mem_bits_r(fence_mem_bits_r), .amo_order_both_r(amo_order_both_r),
    .page_memtype_avail_r(page_memtype_avail_r), .hw_ad_update_r(hw_ad_update_r),
    .ad_fault_r(ad_fault_r), .landing_pad_track_r(landing_pad_track_r),
    .landing_pad_nop_r(landing_pad_nop_r), .shadow_stack_fallback_r(shadow_stack_fallback_r),
    .shadow_pte_010_reserved_r(shadow_pte_010_reserved_r),
    .super_sse_read_zero_r(super_sse_read_zero_r),
    .shadow_swap_virt_instr_r(shadow_swap_virt_instr_r),
    .guest_double_trap_off_r(guest_double_trap_off_r), .guest_time_r(guest_time_r),
    .cnt_done_r(cnt_done_r), .cnt_grant_r(cnt_grant_r), .cnt_virt_fault_r(cnt_virt_fault_r)
  );
  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;
  // ==========================================================
  // shared tasks
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic cycle; ack is sampled at the edge, before that edge's updates land
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_sys iff wb_ack_o === 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(64'(rd), 64'(exp));
  endtask
  task automatic trap(input logic gpf, input logic [63:0] gpa, input logic [63:0] ins);
    @(posedge clk_sys);
    trap_take <= 1'b1;
    trap_guest_page_fault <= gpf;
    trap_implicit_walk <= gpf;
    trap_gpa <= gpa;
    trap_instr_value <= ins;
    @(posedge clk_sys);
    trap_take <= 1'b0;
  endtask
  task automatic cnt(input logic [4:0] i, input logic f);
    @(posedge clk_sys);
    cnt_read_req <= 1'b1;
    cnt_read_idx <= i;
    @(posedge clk_sys);
    cnt_read_req <= 1'b0;
    #1;
    chk(64'({cnt_done_r, cnt_grant_r, cnt_virt_fault_r}), 64'({1'b1, !f, f}));
    // return on an edge so callers change inputs there
    @(posedge clk_sys);
  endtask
  task automatic eff(input logic [14:0] exp);
    @(posedge clk_sys);
    #1;
    chk(64'({fence_mem_bits_r, amo_order_both_r, page_memtype_avail_r, hw_ad_update_r,
      ad_fault_r, landing_pad_track_r, landing_pad_nop_r, shadow_stack_fallback_r,
      shadow_pte_010_reserved_r, super_sse_read_zero_r, shadow_swap_virt_instr_r,
      guest_double_trap_off_r}), 64'(exp));
    @(posedge clk_sys);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_cfg;
    eff(15'h0005);
    bus(1'b1, OFS_ENV_CFG_LO, 32'hffff_ffff);
    bus(1'b1, OFS_ENV_CFG_HI, 32'hffff_ffff);
    rchk(OFS_ENV_CFG_LO, 32'h0000_000d);
    rchk(OFS_ENV_CFG_HI, 32'h6800_0000);
    @(posedge clk_sys);
    fence_io_bits <= 4'ha;
    amo_io_acqrel <= 1'b1;
    ad_update_need <= 1'b1;
    machine_ss_enable <= 1'b1;
    ss_swap_op <= 1'b1;
    eff(15'h0000);
    virt_mode <= 1'b1;
    eff(15'h5740);
    bus(1'b1, OFS_ENV_CFG_LO, 32'h0);
    bus(1'b1, OFS_ENV_CFG_HI, 32'h0);
    eff(15'h00bf);
    virt_mode <= 1'b0;
  endtask
  task automatic t_cnt;
    bus(1'b1, OFS_CNT_GATE, 32'hffff_ffff);
    rchk(OFS_CNT_GATE, 32'h0000_00ff);
    @(posedge clk_sys);
    virt_mode <= 1'b1;
    cnt(5'd1, 1'b0);
    cnt(5'd8, 1'b1);
    guest_user <= 1'b1;
    supervisor_counter_gate <= 32'hffff_fffb;
    cnt(5'd2, 1'b1);
    cnt(5'd0, 1'b0);
    guest_user <= 1'b0;
    bus(1'b1, OFS_CNT_GATE, 32'h0);
    cnt(5'd0, 1'b1);
    machine_counter_gate <= 32'h0;
    cnt(5'd2, 1'b0);
    virt_mode <= 1'b0;
    rchk(OFS_STATUS, 32'h0000_0004);
    bus(1'b1, OFS_STATUS, 32'h0000_0004);
    rchk(OFS_STATUS, 32'h0);
  endtask
  task automatic t_time;
    bus(1'b1, OFS_TOFS_LO, 32'hffff_ffff);
    bus(1'b1, OFS_TOFS_HI, 32'hffff_ffff);
    rchk(OFS_TOFS_HI, 32'hffff_ffff);
    real_time <= 64'h5;
    rchk(OFS_GTIME_LO, 32'h0000_0004);
    rchk(OFS_GTIME_HI, 32'h0);
    chk(guest_time_r, 64'h4);
  endtask
  task automatic t_trap;
    trap(1'b1, 64'h3_ffff_fffc, 64'h1234_5678_9abc_def0);
    rchk(OFS_FADDR_LO, 32'hffff_ffff);
    rchk(OFS_FADDR_HI, 32'h0);
    rchk(OFS_TINFO_LO, 32'h9abc_def0);
    rchk(OFS_TINFO_HI, 32'h0);
    rchk(OFS_STATUS, 32'h0000_0002);
    trap(1'b1, 64'h80, 64'h0);
    rchk(OFS_FADDR_LO, 32'h0000_0020);
    trap(1'b0, 64'h3_ffff_fffc, 64'h0);
    rchk(OFS_FADDR_LO, 32'h0);
    rchk(OFS_TINFO_LO, 32'h0);
    rchk(OFS_STATUS, 32'h0);
    bus(1'b1, OFS_FADDR_HI, 32'hffff_ffff);
    rchk(OFS_FADDR_HI, 32'h003f_ffff);
    bus(1'b1, 8'h40, 32'hffff_ffff);
    rchk(8'h40, 32'h0);
  endtask
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    {virt_mode, guest_user, amo_io_acqrel, ad_update_need} = '0;
    {machine_ss_enable, ss_swap_op, fence_io_bits, real_time} = '0;
    {cnt_read_req, cnt_read_idx, trap_take, trap_guest_page_fault} = '0;
    {trap_implicit_walk, trap_gpa, trap_instr_value} = '0;
    machine_counter_gate = 32'hffff_ffff;
    supervisor_counter_gate = 32'hffff_ffff;
    n_mismatch = 0;
    tests_run = 0;
    nrst = 1'b0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    t_cfg();
    t_cnt();
    t_time();
    t_trap();
    close_out();
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    close_out();
  end
endmodule
